/* src/ccp_compare_pwm.sv */
// Compare and standard PWM channel with an APB register slave.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Compare 16-bit match value with selected 16-bit timebase while compare mode active.
// - On match act on output by mode: toggle, set, clear or pulse.
// - Match sets the match event flag in the same cycle as the action.
// - Modes 0001 and 1011 also clear the selected timebase on match.
// - Match raises ADC trigger pulse when channel is selected as trigger source.
// - Match value written between trigger and clear edges cancels the timebase clear.
// - Writing zero to channel control forces the compare output latch low.
// - Channel output is also given to other peripherals, independent of pin routing.
// - Compare runs in sleep only with running timebase; enabled match wakes device.
// - PWM period is (limit+1) times 4 clocks times prescale.
// - After timer equals limit: clear timer, load duty, set pin unless duty zero.
// - No postscaler affects the PWM period.
// - Duty registers writable anytime; loaded to buffer only at period match.
// - 10-bit timebase is period timer plus two low clock or prescaler bits.
// - Timebase equal to buffered duty clears the pin for rest of period.
// - Duty beyond the period never clears the pin.
// - Resolution is log2 of 4 times (limit+1), ten bits at 255.
// - In sleep the period timer and module state freeze; resume on wake.
// - Reset puts pin in input mode and all registers to reset values.
// - Mode codes: 1000 set, 1001 clear, 1010 pulse, 0010 toggle, 11xx PWM.
// - Duty alignment: right uses low byte and high bits 1:0; left uses high byte.
// - Timer select field 01, 10, 11 picks compare timebase 0, 1 or 2; 00 reserved.
module ccp_compare_pwm #(
    parameter int NUM_TB = 3
) (
    // APB slave
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic                          pready,
    output logic [31:0]                   prdata,
    output logic                          pslverr,
    // Compare timebases (same clock domain)
    input  wire logic [NUM_TB-1:0][15:0]  tb_count_i,
    output logic [NUM_TB-1:0]             tb_clear_o,
    // System
    input  wire logic                     sleep_i,
    output logic                          wake_o,
    output logic                          adc_trig_o,
    // Channel pin and internal copy
    output logic                          channel_pin_o,
    output logic                          channel_pin_oe_o,
    output logic                          channel_periph_o
);
    import ccp_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    ccp_ctrl_t   ctrl_r;
    logic [7:0]  capsel_r;
    logic [7:0]  mlo_r;
    logic [7:0]  mhi_r;
    logic [7:0]  tbsel_r;
    logic [7:0]  plim_r;
    logic [7:0]  ptctl_r;
    logic [7:0]  aux_r;
    logic        match_flag_r;
    logic        ovf_flag_r;
    logic        out_r;
    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;

    // Compare and PWM state
    logic        eq_prev_r;
    logic [15:0] cnt_prev_r;
    logic        pulse_act_r;
    logic        clr_pend_r;
    logic [NUM_TB-1:0] tb_clear_r;
    logic        adc_trig_r;
    logic        wake_r;
    logic [7:0]  ps_cnt_r;
    logic [7:0]  tmr_r;
    logic [9:0]  duty_buf_r;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic        acc;
    logic        wr;
    logic        mapped;
    logic        wr_ctrl;
    logic        wr_match;
    logic [7:0]  wd;
    logic [31:0] rd_nxt;

    // One wait state keeps pready straight from a flip-flop
    assign acc      = psel && penable && pready_r;
    assign wr       = acc && pwrite;
    assign wd       = pwdata[7:0];
    assign wr_ctrl  = wr && (paddr == CCP_OFS_CTRL);
    assign wr_match = wr && ((paddr == CCP_OFS_MLO) || (paddr == CCP_OFS_MHI));

    always_comb begin
        mapped = 1'b1;
        rd_nxt = 32'h0000_0000;
        case (paddr)
            CCP_OFS_CTRL:   rd_nxt[7:0] = {ctrl_r.en, 1'b0, out_r, ctrl_r[4:0]};
            CCP_OFS_CAPSEL: rd_nxt[7:0] = {6'h00, capsel_r[1:0]};
            CCP_OFS_MLO:    rd_nxt[7:0] = mlo_r;
            CCP_OFS_MHI:    rd_nxt[7:0] = mhi_r;
            CCP_OFS_TBSEL:  rd_nxt[7:0] = tbsel_r;
            CCP_OFS_PLIM:   rd_nxt[7:0] = plim_r;
            CCP_OFS_PTCTL:  rd_nxt[7:0] = ptctl_r;
            CCP_OFS_PTCNT:  rd_nxt[7:0] = tmr_r;
            CCP_OFS_AUX:    rd_nxt[7:0] = aux_r;
            CCP_OFS_STAT:   rd_nxt[1:0] = {ovf_flag_r, match_flag_r};
            default:        mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && !mapped;
            if (psel && penable && !pready_r && !pwrite) begin
                prdata_r <= rd_nxt;
            end
        end
    end

    // Register file: every register back to its reset value on any reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r   <= CCP_RST_CTRL;
            capsel_r <= CCP_RST_CAPSEL;
            mlo_r    <= CCP_RST_MATCH;
            mhi_r    <= CCP_RST_MATCH;
            tbsel_r  <= CCP_RST_TBSEL;
            plim_r   <= CCP_RST_PLIM;
            ptctl_r  <= CCP_RST_PTCTL;
            aux_r    <= CCP_RST_AUX;
        end else if (wr) begin
            case (paddr)
                CCP_OFS_CTRL:   ctrl_r   <= {wd[7], 1'b0, 1'b0, wd[4:0]};
                CCP_OFS_CAPSEL: capsel_r <= {6'h00, wd[1:0]};
                CCP_OFS_MLO:    mlo_r    <= wd;
                CCP_OFS_MHI:    mhi_r    <= wd;
                CCP_OFS_TBSEL:  tbsel_r  <= wd;
                CCP_OFS_PLIM:   plim_r   <= wd;
                CCP_OFS_PTCTL:  ptctl_r  <= wd;
                CCP_OFS_AUX:    aux_r    <= wd;
                default:        ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Compare
    // ------------------------------------------------------------
    logic        pwm_mode;
    logic        cmp_mode;
    logic        clr_mode;
    logic        pulse_mode;
    logic        tb_valid;
    logic [1:0]  tb_idx;
    logic [15:0] sel_cnt;
    logic        eq;
    logic        match;

    assign pwm_mode   = ctrl_r.en && (ctrl_r.mode[3:2] == CCP_MODE_PWM_TOP);
    assign cmp_mode   = ctrl_r.en && ((ctrl_r.mode == CCP_MODE_TOG_CLR) || (ctrl_r.mode == CCP_MODE_TOG)
                        || (ctrl_r.mode[3:2] == 2'b10));
    assign clr_mode   = (ctrl_r.mode == CCP_MODE_TOG_CLR) || (ctrl_r.mode == CCP_MODE_PULSE_CLR);
    assign pulse_mode = (ctrl_r.mode == CCP_MODE_PULSE) || (ctrl_r.mode == CCP_MODE_PULSE_CLR);
    // Field value 00 is reserved: no timebase, no compare
    assign tb_valid   = (tbsel_r[1:0] != 2'b00);
    assign tb_idx     = tbsel_r[1:0] - 2'd1;
    assign sel_cnt    = tb_valid ? tb_count_i[tb_idx] : 16'h0000;
    assign eq         = cmp_mode && tb_valid && (sel_cnt == {mhi_r, mlo_r});
    // Only the cycle in which equality begins counts as a match
    assign match      = eq && !eq_prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eq_prev_r  <= 1'b0;
            cnt_prev_r <= 16'h0000;
        end else begin
            eq_prev_r  <= eq;
            cnt_prev_r <= sel_cnt;
        end
    end

    // Sticky flag; a new match wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_flag_r <= 1'b0;
        end else if (match) begin
            match_flag_r <= 1'b1;
        end else if (wr && (paddr == CCP_OFS_STAT) && wd[CCP_STAT_MATCH_BIT]) begin
            match_flag_r <= 1'b0;
        end
    end

    // Trigger at the match edge, timebase clear one edge later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_trig_r <= 1'b0;
            clr_pend_r <= 1'b0;
            tb_clear_r <= '0;
            wake_r     <= 1'b0;
        end else begin
            adc_trig_r <= match && aux_r[CCP_AUX_ADC_BIT];
            clr_pend_r <= match && clr_mode;
            tb_clear_r <= '0;
            // A match value rewrite in between removes the match condition
            if (clr_pend_r && !wr_match && tb_valid) begin
                tb_clear_r[tb_idx] <= 1'b1;
            end
            // Wake is level from the sticky flag, so it also works in sleep
            wake_r     <= match_flag_r && aux_r[CCP_AUX_WAKE_BIT];
        end
    end

    // ------------------------------------------------------------
    // PWM period timer
    // ------------------------------------------------------------
    logic [7:0] ps_last;
    logic [9:0] timebase;
    logic [9:0] tb_nxt;
    logic [9:0] duty_val;
    logic       run;
    logic       tick;
    logic       wrap;

    // Clocks per timer increment: 4 times prescale 1, 4, 16 or 64
    assign ps_last  = 8'((CCP_CLK_PER_INC << (2 * ptctl_r[1:0])) - 1);
    assign timebase = {tmr_r, 2'(ps_cnt_r >> (2 * ptctl_r[1:0]))};
    assign tb_nxt   = tick ? {8'(tmr_r + 8'h01), 2'b00} : {tmr_r, 2'((ps_cnt_r + 8'h01) >> (2 * ptctl_r[1:0]))};
    // Alignment of the 10-bit duty over the two match bytes
    assign duty_val = ctrl_r.duty_alignment_select ? {mhi_r, mlo_r[7:6]} : {mhi_r[1:0], mlo_r};
    // Timer halts in sleep and resumes from its count
    assign run      = ptctl_r[CCP_PTCTL_ON_BIT] && !sleep_i;
    assign tick     = run && (ps_cnt_r == ps_last);
    assign wrap     = tick && (tmr_r == plim_r);

    // No postscaler exists on this path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps_cnt_r   <= 8'h00;
            tmr_r      <= 8'h00;
            duty_buf_r <= 10'h000;
        end else if (run) begin
            ps_cnt_r <= tick ? 8'h00 : ps_cnt_r + 8'h01;
            if (wrap) begin
                tmr_r      <= 8'h00;
                duty_buf_r <= duty_val;
            end else if (tick) begin
                tmr_r <= tmr_r + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_flag_r <= 1'b0;
        end else if (wrap) begin
            ovf_flag_r <= 1'b1;
        end else if (wr && (paddr == CCP_OFS_STAT) && wd[CCP_STAT_OVF_BIT]) begin
            ovf_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Output latch
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_r       <= 1'b0;
            pulse_act_r <= 1'b0;
        end else if (wr_ctrl && (wd == 8'h00)) begin
            out_r       <= 1'b0;
            pulse_act_r <= 1'b0;
        end else if (pwm_mode) begin
            pulse_act_r <= 1'b0;
            // Falls as the timebase reaches duty, not one clock late; duty past the period never hits
            if (run && ((tb_nxt == duty_buf_r) || (timebase == duty_buf_r))) begin
                out_r <= 1'b0;
            end
            if (wrap) begin
                out_r <= (duty_val != 10'h000);
            end
        end else if (cmp_mode) begin
            if (match) begin
                case (ctrl_r.mode)
                    CCP_MODE_TOG_CLR, CCP_MODE_TOG: out_r <= !out_r;
                    CCP_MODE_SET:                   out_r <= 1'b1;
                    CCP_MODE_CLR:                   out_r <= 1'b0;
                    default:                        out_r <= 1'b1;
                endcase
                pulse_act_r <= pulse_mode;
            end else if (pulse_act_r && (sel_cnt != cnt_prev_r)) begin
                // Timebase stepped once: pulse ends
                out_r       <= 1'b0;
                pulse_act_r <= 1'b0;
            end
        end else begin
            // Disabled or mode zero resets the set and clear state
            out_r       <= 1'b0;
            pulse_act_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready           = pready_r;
    assign prdata           = prdata_r;
    assign pslverr          = pslverr_r;
    assign tb_clear_o       = tb_clear_r;
    assign adc_trig_o       = adc_trig_r;
    assign wake_o           = wake_r;
    assign channel_pin_o    = out_r;
    assign channel_pin_oe_o = aux_r[CCP_AUX_DRV_BIT];
    assign channel_periph_o = out_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_flag_on_match;
        @(posedge pclk) disable iff (!presetn) match |=> match_flag_r;
    endproperty
    a_flag_on_match: assert property (p_flag_on_match) else $error("match flag not set");
    property p_adc_trig;
        @(posedge pclk) disable iff (!presetn)
            match && aux_r[CCP_AUX_ADC_BIT] |=> adc_trig_o ##1 !adc_trig_o;
    endproperty
    a_adc_trig: assert property (p_adc_trig) else $error("adc trigger pulse wrong");
    property p_tb_clear;
        @(posedge pclk) disable iff (!presetn)
            match && clr_mode ##1 !wr_match |=> (tb_clear_o != '0);
    endproperty
    a_tb_clear: assert property (p_tb_clear) else $error("timebase not cleared");

    property p_clear_cancel;
        @(posedge pclk) disable iff (!presetn) clr_pend_r && wr_match |=> (tb_clear_o == '0);
    endproperty
    a_clear_cancel: assert property (p_clear_cancel) else $error("clear not cancelled");

    property p_zero_ctrl;
        @(posedge pclk) disable iff (!presetn) wr_ctrl && (wd == 8'h00) |=> !channel_pin_o;
    endproperty
    a_zero_ctrl: assert property (p_zero_ctrl) else $error("latch not forced low");

    property p_match_once;
        @(posedge pclk) disable iff (!presetn) match ##1 $stable(sel_cnt) && $stable({mhi_r, mlo_r}) |-> !match;
    endproperty
    a_match_once: assert property (p_match_once) else $error("repeated match");

    property p_set_mode;
        @(posedge pclk) disable iff (!presetn)
            match && (ctrl_r.mode == CCP_MODE_SET) && !wr_ctrl |=> channel_pin_o;
    endproperty
    a_set_mode: assert property (p_set_mode) else $error("set mode failed");

    property p_wrap_load;
        @(posedge pclk) disable iff (!presetn)
            wrap |=> (tmr_r == 8'h00) && (duty_buf_r == $past(duty_val));
    endproperty
    a_wrap_load: assert property (p_wrap_load) else $error("period wrap wrong");

    property p_sleep_freeze;
        @(posedge pclk) disable iff (!presetn) sleep_i |=> $stable(tmr_r) && $stable(ps_cnt_r);
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("timer moved in sleep");

    property p_duty_clear;
        @(posedge pclk) disable iff (!presetn)
            pwm_mode && run && (timebase == duty_buf_r) && !wrap && !wr_ctrl |=> !channel_pin_o;
    endproperty
    a_duty_clear: assert property (p_duty_clear) else $error("pin not cleared at duty");

    c_pulse:   cover property (@(posedge pclk) disable iff (!presetn) match && pulse_mode ##[1:20] !out_r);
    c_wrap:    cover property (@(posedge pclk) disable iff (!presetn) pwm_mode && wrap);
    c_cancel:  cover property (@(posedge pclk) disable iff (!presetn) clr_pend_r && wr_match);

endmodule // ccp_compare_pwm

`default_nettype wire

/* src/ccp_pkg.sv */
// Package for the compare and PWM channel: register map, fields, reset values, codes.
package ccp_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CCP_OFS_CTRL   = 8'h00;
    localparam logic [7:0] CCP_OFS_CAPSEL = 8'h04;
    localparam logic [7:0] CCP_OFS_MLO    = 8'h08;
    localparam logic [7:0] CCP_OFS_MHI    = 8'h0C;
    localparam logic [7:0] CCP_OFS_TBSEL  = 8'h10;
    localparam logic [7:0] CCP_OFS_PLIM   = 8'h14;
    localparam logic [7:0] CCP_OFS_PTCTL  = 8'h18;
    localparam logic [7:0] CCP_OFS_PTCNT  = 8'h1C;
    localparam logic [7:0] CCP_OFS_AUX    = 8'h20;
    localparam logic [7:0] CCP_OFS_STAT   = 8'h24;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CCP_PTCTL_ON_BIT  = 7;
    localparam int CCP_AUX_ADC_BIT   = 0;
    localparam int CCP_AUX_WAKE_BIT  = 1;
    localparam int CCP_AUX_DRV_BIT   = 2;
    localparam int CCP_STAT_MATCH_BIT = 0;
    localparam int CCP_STAT_OVF_BIT   = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CCP_RST_CTRL   = 8'h00;
    localparam logic [7:0] CCP_RST_CAPSEL = 8'h00;
    localparam logic [7:0] CCP_RST_MATCH  = 8'h00;
    localparam logic [7:0] CCP_RST_TBSEL  = 8'h55;
    localparam logic [7:0] CCP_RST_PLIM   = 8'hFF;
    localparam logic [7:0] CCP_RST_PTCTL  = 8'h00;
    localparam logic [7:0] CCP_RST_AUX    = 8'h00;

    // ------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------
    localparam logic [3:0] CCP_MODE_OFF       = 4'h0;
    localparam logic [3:0] CCP_MODE_TOG_CLR   = 4'h1;
    localparam logic [3:0] CCP_MODE_TOG       = 4'h2;
    localparam logic [3:0] CCP_MODE_SET       = 4'h8;
    localparam logic [3:0] CCP_MODE_CLR       = 4'h9;
    localparam logic [3:0] CCP_MODE_PULSE     = 4'hA;
    localparam logic [3:0] CCP_MODE_PULSE_CLR = 4'hB;
    localparam logic [1:0] CCP_MODE_PWM_TOP   = 2'b11;

    // Period timer sub-count per increment is 4 system clocks times prescale
    localparam int CCP_CLK_PER_INC = 4;

    typedef struct packed {
        logic       en;
        logic       rsvd6;
        logic       out;
        logic       duty_alignment_select;
        logic [3:0] mode;
    } ccp_ctrl_t;

endpackage : ccp_pkg

/* sim/ccp_tb_model.sv */
// Timebase partner model: three 16-bit counts that the channel may clear.
`timescale 1ns/1ns
`default_nettype none
module ccp_tb_model (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Timebase side
    input  wire logic             run_i,
    input  wire logic [2:0]       clr_i,
    output logic      [2:0][15:0] cnt_o
);
    // Synchronous counting, at most one step per clock; no asynchronous count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_o <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                // Clear wins over the step so the restart is seen at once
                if (clr_i[i]) begin
                    cnt_o[i] <= 16'h0000;
                end else if (run_i) begin
                    cnt_o[i] <= cnt_o[i] + 16'h0001;
                end
            end
        end
    end
endmodule // ccp_tb_model
`default_nettype wire

/* sim/ccp_compare_and_pwm_bench.sv */
// Self-checking bench for the compare and PWM channel.
`timescale 1ns/1ns
`default_nettype none
module ccp_compare_and_pwm_bench;
    import ccp_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic x;} ccp_row_t;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_i, run_i;
    logic             wake, trig, pin, oe, periph, err;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, rd;
    logic [2:0][15:0] cnt;
    logic [2:0]       clr;
    int               bad_count, n_checks, hi;
    ccp_row_t rows [7] = '{'{8'h04, 8'h03, 8'h03, 1'b0}, '{8'h08, 8'hA5, 8'hA5, 1'b0},
        '{8'h0C, 8'h5A, 8'h5A, 1'b0}, '{8'h10, 8'h02, 8'h02, 1'b0}, '{8'h14, 8'h3C, 8'h3C, 1'b0},
        '{8'h00, 8'h30, 8'h10, 1'b0}, '{8'h30, 8'hFF, 8'h00, 1'b1}};
    logic [7:0] pt [5] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h81};
    logic [7:0] duty [5] = '{8'h02, 8'h05, 8'h00, 8'h01, 8'h02};
    int         hi_exp [5] = '{24, 48, 0, 12, 24};

    ccp_compare_pwm dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .tb_count_i(cnt),
        .tb_clear_o(clr), .sleep_i(sleep_i), .wake_o(wake), .adc_trig_o(trig), .channel_pin_o(pin),
        .channel_pin_oe_o(oe), .channel_periph_o(periph));
    ccp_tb_model tb_u (.pclk(pclk), .presetn(presetn), .run_i(run_i), .clr_i(clr), .cnt_o(cnt));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Values read right after an edge are those sampled at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    task automatic count_hi(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge pclk);
            hi += int'(pin === 1'b1);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        #2_000_000;
        bad_count++;
        test_done();
    end

    initial begin
        {presetn, psel, penable, pwrite, sleep_i, run_i} = 6'b00_0000;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        do_reset();
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 8'h00);
            chk("read data", {24'h00_0000, rows[i].e}, rd);
            chk("slave error", rows[i].x, err);
        end
        $display("register table done");
        do_reset();
        apb(1'b0, CCP_OFS_TBSEL, 8'h00);
        chk("timebase select", {24'h00_0000, CCP_RST_TBSEL}, rd);
        apb(1'b0, CCP_OFS_PLIM, 8'h00);
        chk("period limit", {24'h00_0000, CCP_RST_PLIM}, rd);
        chk("pin driver", 1'b0, oe);
        $display("reset test done");
        apb(1'b1, CCP_OFS_TBSEL, 8'h01);
        apb(1'b1, CCP_OFS_MLO, 8'h10);
        apb(1'b1, CCP_OFS_AUX, 8'h01);
        apb(1'b1, CCP_OFS_CTRL, {4'h8, CCP_MODE_TOG_CLR});
        run_i <= 1'b1;
        hi = 0;
        while (trig !== 1'b1 && hi < 40) begin
            @(posedge pclk);
            hi++;
        end
        chk("conversion trigger", 1'b1, trig);
        chk("pin toggled", 1'b1, pin);
        chk("peripheral copy", 1'b1, periph);
        @(posedge pclk);
        chk("trigger width", 1'b0, trig);
        chk("timebase clear", 3'b001, clr);
        repeat (2) @(posedge pclk);
        run_i <= 1'b0;
        chk("timebase restarted", 1'b1, cnt[0] < 16'h0004);
        apb(1'b0, CCP_OFS_STAT, 8'h00);
        chk("match flag", 1'b1, rd[CCP_STAT_MATCH_BIT]);
        apb(1'b1, CCP_OFS_AUX, 8'h07);
        @(posedge pclk);
        chk("wake request", 1'b1, wake);
        chk("pin driver on", 1'b1, oe);
        apb(1'b1, CCP_OFS_CTRL, 8'h00);
        @(posedge pclk);
        chk("latch cleared", 1'b0, pin);
        // Count stands at 2: it meets 3 in the access wait state, the rewrite lands between trigger and clear
        apb(1'b1, CCP_OFS_MLO, 8'h03);
        apb(1'b1, CCP_OFS_CTRL, {4'h8, CCP_MODE_PULSE_CLR});
        run_i <= 1'b1;
        apb(1'b1, CCP_OFS_MLO, 8'h40);
        run_i <= 1'b0;
        chk("clear cancelled", 3'b000, clr);
        apb(1'b1, CCP_OFS_MLO, 8'h09);
        apb(1'b1, CCP_OFS_CTRL, {4'h8, CCP_MODE_PULSE});
        run_i <= 1'b1;
        count_hi(8);
        run_i <= 1'b0;
        chk("pulse width", 1, hi);
        apb(1'b1, CCP_OFS_MLO, 8'h10);
        apb(1'b1, CCP_OFS_CTRL, {4'h8, CCP_MODE_SET});
        run_i <= 1'b1;
        repeat (4) @(posedge pclk);
        run_i <= 1'b0;
        chk("pin set", 1'b1, pin);
        $display("compare test done");
        apb(1'b1, CCP_OFS_AUX, 8'h00);
        apb(1'b1, CCP_OFS_PLIM, 8'h00);
        apb(1'b1, CCP_OFS_CTRL, 8'h8C);
        foreach (duty[i]) begin
            apb(1'b1, CCP_OFS_MLO, duty[i]);
            apb(1'b1, CCP_OFS_STAT, 8'h02);
            apb(1'b1, CCP_OFS_PTCTL, pt[i]);
            repeat (40) @(posedge pclk);
            apb(1'b0, CCP_OFS_STAT, 8'h00);
            chk("overflow flag", 1'b1, rd[CCP_STAT_OVF_BIT]);
            apb(1'b1, CCP_OFS_AUX, 8'h04);
            count_hi(48);
            chk("pwm high time", hi_exp[i], hi);
        end
        sleep_i <= 1'b1;
        count_hi(24);
        chk("frozen pin", 1'b1, hi == 0 || hi == 24);
        sleep_i <= 1'b0;
        $display("pwm test done");
        test_done();
    end
endmodule // ccp_compare_and_pwm_bench
`default_nettype wire
